// ===== src/hpa_device.sv
// Summary of operation
// - Single-slot: shift command bits on serial clock rise
// - Multi-slot: pass shifted stream to next device
// - Direct: select low 1.5 V, high 3.3 V
// - Direct: controller changes voltage select only power off
// - Serial mode: both indicators default off
// - Direct: power indicator follows its enable input
// - Power indicator low at supply rise forces enable
// - Supply ok: attention shows command or input
// - Supply down: attention shows auxiliary fault latch
// - Aux power on while aux switch low
// - Aux fault cleared only by switch deassert
// - Serial: button press sets a flag bit
// - Direct: power request turns main power on
// - Direct: request deassert clears main fault
// - Serial: speed pin read as card capability
// - Clock enable low, command speed bit clear: drive speed pin open-drain
// - Mode strap stored at supply rise, kept
// - Serial out high at supply rise: multi-slot
// - Latch clock rise moves shift into command
// - Serial out changes on serial clock rise
`timescale 1ns/1ps
`include "hpa_cfg.svh"
module hpa_device (
  input wire logic pclk,
  input wire logic presetn,
  hpa_link_if.dev link,
  input wire logic main_fault_evt,
  input wire logic aux_fault_evt,
  output logic slot_a_main_power_on,
  output logic slot_a_aux_power_on,
  output logic slot_a_iov_3v3,
  output logic forced_enable,
  output logic direct_mode,
  output logic multi_slot,
  output logic button_pressed,
  output logic slot_a_main_fault_latch,
  output logic slot_a_aux_fault_latch,
  output logic speed66_cap,
  output hpa_pkg::hpa_byte_t cmd_latched
);
  import hpa_pkg::*;

  // ==========================================================
  // Pin sampling
  logic [`HPA_PIN_W-1:0] pins_raw;
  logic [`HPA_PIN_W-1:0] pins;
  logic [`HPA_PIN_W-1:0] pins_prev;

  assign pins_raw[`HPA_PIN_SUP] = link.supply_ok;
  assign pins_raw[`HPA_PIN_DIR] = link.direct_strap;
  assign pins_raw[`HPA_PIN_CMD] = link.slot_a_cmd_in;
  assign pins_raw[`HPA_PIN_SCLK] = link.slot_a_serial_clk;
  assign pins_raw[`HPA_PIN_LCLK] = link.slot_a_latch_clk;
  assign pins_raw[`HPA_PIN_BTN] = link.slot_a_attn_button_n;
  assign pins_raw[`HPA_PIN_SW] = link.slot_a_aux_switch_n;
  assign pins_raw[`HPA_PIN_CKEN] = link.slot_a_clock_enable_n;
  assign pins_raw[`HPA_PIN_SO] = link.serial_out_level;
  assign pins_raw[`HPA_PIN_PLED] = link.power_led_level;
  assign pins_raw[`HPA_PIN_S66] = link.speed66_level;

  // Every pin is asynchronous to pclk, so all of them go through two stages
  hpa_sync #(.W(`HPA_PIN_W)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins_raw),
    .q(pins)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins;
    end
  end

  // ==========================================================
  // Edges and decoded pin meanings
  wire supply_on = pins[`HPA_PIN_SUP];
  wire supply_rise = pins[`HPA_PIN_SUP] & ~pins_prev[`HPA_PIN_SUP];
  wire sclk_rise = pins[`HPA_PIN_SCLK] & ~pins_prev[`HPA_PIN_SCLK];
  wire latch_rise = pins[`HPA_PIN_LCLK] & ~pins_prev[`HPA_PIN_LCLK];
  wire btn_fall = ~pins[`HPA_PIN_BTN] & pins_prev[`HPA_PIN_BTN];
  wire sw_rise = pins[`HPA_PIN_SW] & ~pins_prev[`HPA_PIN_SW];
  wire serial_active = supply_on & ~direct_mode;
  wire ser_shift = serial_active & sclk_rise;
  wire ser_latch = serial_active & latch_rise;

  // Direct mode reuses the serial pins as plain level inputs
  wire slot_a_iov_select = pins[`HPA_PIN_CMD];
  wire slot_a_power_led_in = pins[`HPA_PIN_SCLK];
  wire slot_a_attn_led_in = pins[`HPA_PIN_LCLK];
  wire slot_a_main_power_req = pins[`HPA_PIN_BTN];

  // ==========================================================
  // Serial datapath
  hpa_byte_t shift_reg;
  hpa_byte_t status_shift;
  logic serial_out;
  wire hpa_byte_t status_now;

  assign status_now = {2'b00, multi_slot, slot_a_main_power_on, speed66_cap,
                       slot_a_aux_fault_latch, slot_a_main_fault_latch, button_pressed};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= `HPA_CMD_RST;
      status_shift <= '0;
      serial_out <= 1'b0;
      cmd_latched <= `HPA_CMD_RST;
    end else if (!supply_on) begin
      // Supply down returns the command image to its all-off default
      cmd_latched <= `HPA_CMD_RST;
      serial_out <= 1'b0;
    end else if (ser_latch) begin
      cmd_latched <= shift_reg;
      status_shift <= status_now;
      serial_out <= multi_slot ? shift_reg[7] : status_now[7];
    end else if (ser_shift) begin
      shift_reg <= {shift_reg[6:0], pins[`HPA_PIN_CMD]};
      status_shift <= {status_shift[6:0], 1'b0};
      // Output shows the current top bit, so a chained part lags by exactly one byte
      serial_out <= multi_slot ? shift_reg[6] : status_shift[6];
    end
  end

  // ==========================================================
  // Straps taken at the supply rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_mode <= 1'b0;
      multi_slot <= 1'b0;
      forced_enable <= 1'b0;
    end else if (supply_rise) begin
      direct_mode <= pins[`HPA_PIN_DIR];
      multi_slot <= pins[`HPA_PIN_SO];
      forced_enable <= ~pins[`HPA_PIN_PLED];
    end
  end

  // ==========================================================
  // Slot control decisions
  wire power_req = direct_mode ? slot_a_main_power_req : cmd_latched[`HPA_CMD_PWR];
  wire next_main_on = supply_on & ~slot_a_main_fault_latch & (forced_enable | power_req);
  wire next_iov = direct_mode ? slot_a_iov_select : cmd_latched[`HPA_CMD_IOV];
  wire next_pled = supply_on & (direct_mode ? slot_a_power_led_in : cmd_latched[`HPA_CMD_PLED]);
  wire attn_cmd = direct_mode ? slot_a_attn_led_in : cmd_latched[`HPA_CMD_ATTN];
  wire next_attn = supply_on ? attn_cmd : slot_a_aux_fault_latch;
  wire next_aux_on = ~pins[`HPA_PIN_SW];
  // Open-drain: pulling low advertises the slower bus speed
  wire next_speed_oe = ~pins[`HPA_PIN_CKEN] & ~cmd_latched[`HPA_CMD_S66];

  // Fault and button flags: a set in the same cycle as a clear wins
  wire mflt_set = main_fault_evt & slot_a_main_power_on;
  wire mflt_clr = (supply_on & direct_mode & btn_fall)
                | (ser_latch & ~shift_reg[`HPA_CMD_PWR]);
  wire aflt_set = aux_fault_evt & slot_a_aux_power_on;
  wire aflt_clr = sw_rise;
  wire btn_set = serial_active & btn_fall;
  wire btn_clr = ser_latch & shift_reg[`HPA_CMD_BCLR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_a_main_fault_latch <= 1'b0;
      slot_a_aux_fault_latch <= 1'b0;
      button_pressed <= 1'b0;
    end else begin
      slot_a_main_fault_latch <= mflt_set | (slot_a_main_fault_latch & ~mflt_clr);
      slot_a_aux_fault_latch <= aflt_set | (slot_a_aux_fault_latch & ~aflt_clr);
      button_pressed <= btn_set | (button_pressed & ~btn_clr);
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_a_main_power_on <= 1'b0;
      slot_a_aux_power_on <= 1'b0;
      slot_a_iov_3v3 <= 1'b0;
      speed66_cap <= 1'b0;
      link.dev_so <= 1'b0;
      link.dev_so_oe <= 1'b0;
      link.dev_pled_oe <= 1'b0;
      link.dev_attn_oe <= 1'b0;
      link.dev_speed66_oe <= 1'b0;
    end else begin
      slot_a_main_power_on <= next_main_on;
      slot_a_aux_power_on <= next_aux_on;
      slot_a_iov_3v3 <= next_iov;
      // Only meaningful while the pin is not driven by this end
      speed66_cap <= pins[`HPA_PIN_S66] & ~link.dev_speed66_oe;
      link.dev_so <= serial_out;
      // Released while supply is down so the strap can be read
      link.dev_so_oe <= serial_active;
      link.dev_pled_oe <= next_pled;
      link.dev_attn_oe <= next_attn;
      link.dev_speed66_oe <= next_speed_oe;
    end
  end

endmodule : hpa_device

// ===== src/hpa_cfg.svh
`ifndef HPA_CFG_SVH
`define HPA_CFG_SVH

// ==========================================================
// Timing
`define HPA_CLK_NS 8
`define HPA_SCLK_PERIOD_NS 160
`define HPA_SCLK_HALF (`HPA_SCLK_PERIOD_NS / (2 * `HPA_CLK_NS))

// ==========================================================
// Serial command byte fields
`define HPA_CMD_PWR 0
`define HPA_CMD_PLED 1
`define HPA_CMD_ATTN 2
`define HPA_CMD_IOV 3
`define HPA_CMD_S66 4
`define HPA_CMD_BCLR 5
`define HPA_CMD_RST 8'h00

// ==========================================================
// Status byte fields
`define HPA_ST_BTN 0
`define HPA_ST_MFLT 1
`define HPA_ST_AFLT 2
`define HPA_ST_CAP66 3
`define HPA_ST_MAIN 4
`define HPA_ST_MULTI 5

// ==========================================================
// Device pin sampling vector
`define HPA_PIN_W 11
`define HPA_PIN_SUP 0
`define HPA_PIN_DIR 1
`define HPA_PIN_CMD 2
`define HPA_PIN_SCLK 3
`define HPA_PIN_LCLK 4
`define HPA_PIN_BTN 5
`define HPA_PIN_SW 6
`define HPA_PIN_CKEN 7
`define HPA_PIN_SO 8
`define HPA_PIN_PLED 9
`define HPA_PIN_S66 10

// ==========================================================
// Host APB map
`define HPA_REG_CTRL 12'h000
`define HPA_REG_DIRECT 12'h004
`define HPA_REG_CMD 12'h008
`define HPA_REG_STATUS 12'h00c
`define HPA_CTRL_RST 8'h30
`define HPA_CTRL_SUP 0
`define HPA_CTRL_DIR 1
`define HPA_CTRL_MULTI 2
`define HPA_CTRL_FORCE 3
`define HPA_CTRL_SW 4
`define HPA_CTRL_CKEN 5
`define HPA_CTRL_CARD33 6
`define HPA_CTRL_BTN 7
`define HPA_DIR_IOV 0
`define HPA_DIR_PLED 1
`define HPA_DIR_ATTN 2
`define HPA_DIR_PWR 3

`endif

// ===== src/hpa_pkg.sv
package hpa_pkg;
  typedef logic [7:0] hpa_byte_t;
  typedef enum logic [3:0] {
    HPA_IDLE = 4'h1,
    HPA_LOW = 4'h2,
    HPA_HIGH = 4'h4,
    HPA_LATCH = 4'h8
  } hpa_ser_state_t;
endpackage : hpa_pkg

// ===== src/hpa_link_if.sv
`timescale 1ns/1ps
interface hpa_link_if;
  logic supply_ok;
  logic direct_strap;
  logic slot_a_cmd_in;
  logic slot_a_serial_clk;
  logic slot_a_latch_clk;
  logic slot_a_attn_button_n;
  logic slot_a_aux_switch_n;
  logic slot_a_clock_enable_n;
  logic host_so;
  logic host_so_oe;
  logic host_pled_oe;
  logic host_speed66_oe;
  logic dev_so;
  logic dev_so_oe;
  logic dev_pled_oe;
  logic dev_attn_oe;
  logic dev_speed66_oe;
  logic serial_out_level;
  logic power_led_level;
  logic attn_led_level;
  logic speed66_level;
  // ==========================================================
  // Wire levels; pulls stand in for the board resistors
  assign serial_out_level = dev_so_oe ? dev_so : (host_so_oe ? host_so : 1'b0);
  assign power_led_level = ~(dev_pled_oe | host_pled_oe);
  assign attn_led_level = ~dev_attn_oe;
  assign speed66_level = ~(dev_speed66_oe | host_speed66_oe);
  modport dev (
    input supply_ok, direct_strap, slot_a_cmd_in, slot_a_serial_clk, slot_a_latch_clk,
    input slot_a_attn_button_n, slot_a_aux_switch_n, slot_a_clock_enable_n,
    input serial_out_level, power_led_level, speed66_level,
    output dev_so, dev_so_oe, dev_pled_oe, dev_attn_oe, dev_speed66_oe
  );
  modport host (
    output supply_ok, direct_strap, slot_a_cmd_in, slot_a_serial_clk, slot_a_latch_clk,
    output slot_a_attn_button_n, slot_a_aux_switch_n, slot_a_clock_enable_n,
    output host_so, host_so_oe, host_pled_oe, host_speed66_oe,
    input serial_out_level, power_led_level, attn_led_level, speed66_level
  );
endinterface : hpa_link_if

// ===== src/hpa_sync.sv
`timescale 1ns/1ps
module hpa_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // ==========================================================
  // Two stages; only the second stage is visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : hpa_sync

// ===== src/hpa_host.sv
`timescale 1ns/1ps
`include "hpa_cfg.svh"
module hpa_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  hpa_link_if.host link
);
  import hpa_pkg::*;

  // ==========================================================
  // Register file
  logic [7:0] ctrl;
  logic [3:0] dreg;
  hpa_byte_t txd;
  hpa_byte_t rxd;
  hpa_byte_t status;
  hpa_ser_state_t state;
  logic [7:0] cnt;
  logic [2:0] nbit;
  logic [3:0] lv;

  hpa_sync #(.W(4)) u_lvl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.speed66_level, link.attn_led_level, link.power_led_level, link.serial_out_level}),
    .q(lv)
  );

  wire busy = (state != HPA_IDLE);
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = (paddr == `HPA_REG_CTRL);
  wire hit_dir = (paddr == `HPA_REG_DIRECT);
  wire hit_cmd = (paddr == `HPA_REG_CMD);
  wire hit_stat = (paddr == `HPA_REG_STATUS);
  wire mapped = hit_ctrl | hit_dir | hit_cmd | hit_stat;
  wire [31:0] rdata = hit_ctrl ? {24'h0, ctrl}
                    : hit_dir ? {28'h0, dreg}
                    : hit_cmd ? {24'h0, txd}
                    : hit_stat ? {13'h0, lv[3:1], status, 7'h0, busy} : 32'h0;
  // A command written while the engine runs is dropped
  wire start = wr & hit_cmd & ~busy;
  wire tick = (cnt == 8'(`HPA_SCLK_HALF - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `HPA_CTRL_RST;
      dreg <= 4'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= rdata;
        pslverr <= ~mapped;
      end
      if (wr & hit_ctrl) begin
        ctrl <= pwdata[7:0];
      end
      if (wr & hit_dir) begin
        dreg <= pwdata[3:0];
      end
    end
  end

  // ==========================================================
  // Serial engine: one byte out, status byte in, then a latch pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HPA_IDLE;
      cnt <= 8'h00;
      nbit <= 3'h0;
      txd <= 8'h00;
      rxd <= 8'h00;
      status <= 8'h00;
    end else begin
      cnt <= (busy & ~tick) ? cnt + 8'h01 : 8'h00;
      case (state)
        HPA_IDLE: begin
          if (start) begin
            txd <= pwdata[7:0];
            nbit <= 3'h0;
            state <= HPA_LOW;
          end
        end
        HPA_LOW: begin
          if (tick) begin
            // Device moved its bit on the previous rise; sample before the next one
            rxd <= {rxd[6:0], lv[0]};
            state <= HPA_HIGH;
          end
        end
        HPA_HIGH: begin
          if (tick) begin
            txd <= {txd[6:0], 1'b0};
            nbit <= nbit + 3'h1;
            state <= (nbit == 3'h7) ? HPA_LATCH : HPA_LOW;
          end
        end
        HPA_LATCH: begin
          if (tick) begin
            status <= rxd;
            state <= HPA_IDLE;
          end
        end
        default: state <= HPA_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin drivers
  wire dir = ctrl[`HPA_CTRL_DIR];
  wire next_btn = dir ? dreg[`HPA_DIR_PWR] : ~ctrl[`HPA_CTRL_BTN];
  // In direct mode, voltage select moves only while power request is off now and after
  wire iov_ok = dir & ~dreg[`HPA_DIR_PWR] & ~link.slot_a_attn_button_n;
  wire next_cmd = dir ? (iov_ok ? dreg[`HPA_DIR_IOV] : link.slot_a_cmd_in) : txd[7];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.supply_ok <= 1'b0;
      link.direct_strap <= 1'b0;
      link.slot_a_cmd_in <= 1'b0;
      link.slot_a_serial_clk <= 1'b0;
      link.slot_a_latch_clk <= 1'b0;
      link.slot_a_attn_button_n <= 1'b1;
      link.slot_a_aux_switch_n <= 1'b1;
      link.slot_a_clock_enable_n <= 1'b1;
      link.host_so <= 1'b0;
      link.host_so_oe <= 1'b1;
      link.host_pled_oe <= 1'b0;
      link.host_speed66_oe <= 1'b0;
    end else begin
      link.supply_ok <= ctrl[`HPA_CTRL_SUP];
      link.direct_strap <= dir;
      link.slot_a_cmd_in <= next_cmd;
      link.slot_a_serial_clk <= dir ? dreg[`HPA_DIR_PLED] : (state == HPA_HIGH);
      link.slot_a_latch_clk <= dir ? dreg[`HPA_DIR_ATTN] : (state == HPA_LATCH);
      // In direct mode, deasserting the power request is how software clears a main fault
      link.slot_a_attn_button_n <= next_btn;
      // Deasserting the aux switch is how software clears an aux fault
      link.slot_a_aux_switch_n <= ctrl[`HPA_CTRL_SW];
      link.slot_a_clock_enable_n <= ctrl[`HPA_CTRL_CKEN];
      link.host_so <= ctrl[`HPA_CTRL_MULTI];
      // Straps stay driven one cycle past the supply rise, so the device still samples them
      link.host_so_oe <= ~link.supply_ok;
      link.host_pled_oe <= ctrl[`HPA_CTRL_FORCE] & ~link.supply_ok;
      link.host_speed66_oe <= ctrl[`HPA_CTRL_CARD33];
    end
  end

endmodule : hpa_host

// ===== tb/hpa_link_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Link checker: watches only the wires between the two ends
module hpa_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic supply_ok,
  input wire logic direct_strap,
  input wire logic slot_a_serial_clk,
  input wire logic slot_a_latch_clk,
  input wire logic slot_a_aux_switch_n,
  input wire logic slot_a_clock_enable_n,
  input wire logic dev_so,
  input wire logic dev_so_oe,
  input wire logic dev_pled_oe,
  input wire logic dev_attn_oe,
  input wire logic dev_speed66_oe
);
  logic up_d;
  logic dir_mode;
  logic fresh;
  logic [3:0] up_cnt;
  logic [3:0] dn_cnt;
  // Mode settles a few cycles after supply rise because the pins pass a synchroniser
  wire rise_up = supply_ok & ~up_d;
  wire dir_up = dir_mode & supply_ok & (up_cnt > 4'd8);
  wire ser_up = ~dir_mode & supply_ok & (up_cnt > 4'd8);
  wire aux_idle = ~supply_ok & slot_a_aux_switch_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_d <= 1'b0;
      dir_mode <= 1'b0;
      fresh <= 1'b0;
      up_cnt <= 4'h0;
      dn_cnt <= 4'h0;
    end else begin
      up_d <= supply_ok;
      dir_mode <= rise_up ? direct_strap : dir_mode;
      fresh <= rise_up | (fresh & ~slot_a_latch_clk);
      up_cnt <= !supply_ok ? 4'h0 : ((up_cnt == 4'hf) ? up_cnt : up_cnt + 4'h1);
      dn_cnt <= !aux_idle ? 4'h0 : ((dn_cnt == 4'hf) ? dn_cnt : dn_cnt + 4'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  sequence s_dir_change(sig);
    dir_up ##0 $changed(sig);
  endsequence
  property p_pled_follow;
    s_dir_change(slot_a_serial_clk) |-> ##[1:6] (dev_pled_oe == slot_a_serial_clk);
  endproperty
  property p_attn_follow;
    s_dir_change(slot_a_latch_clk) |-> ##[1:6] (dev_attn_oe == slot_a_latch_clk);
  endproperty
  property p_speed_drive;
    s_dir_change(slot_a_clock_enable_n) ##0 !slot_a_clock_enable_n |-> ##[1:6] dev_speed66_oe;
  endproperty
  property p_speed_input;
    slot_a_clock_enable_n [*6] |-> !dev_speed66_oe;
  endproperty
  property p_so_on_clk;
    dev_so_oe && $past(dev_so_oe) && $changed(dev_so) |-> $past(slot_a_serial_clk, 2) || $past(slot_a_latch_clk, 2);
  endproperty
  property p_serial_default;
    ser_up && fresh |-> !dev_pled_oe && !dev_attn_oe;
  endproperty
  property p_aux_attn;
    (dn_cnt > 4'd8) |-> !dev_attn_oe;
  endproperty
  property p_so_release;
    !supply_ok [*6] |-> !dev_so_oe;
  endproperty
  a_pled_follow: assert property (p_pled_follow) else $error("power led not following its input");
  a_attn_follow: assert property (p_attn_follow) else $error("attention led not following its input");
  a_speed_drive: assert property (p_speed_drive) else $error("speed pin not driven");
  a_speed_input: assert property (p_speed_input) else $error("speed pin driven while clock disabled");
  a_so_on_clk: assert property (p_so_on_clk) else $error("serial out moved off clock rise");
  a_serial_default: assert property (p_serial_default) else $error("indicator on before command");
  a_aux_attn: assert property (p_aux_attn) else $error("attention led on with cleared aux latch");
  a_so_release: assert property (p_so_release) else $error("serial out driven while supply down");
endmodule : hpa_link_assertions

// ===== tb/hot_plug_slot_a_control_pins_tb.sv
`timescale 1ns/1ps
`include "hpa_cfg.svh"
module hot_plug_slot_a_control_pins_tb;
  import hpa_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic main_fault_evt = 1'b0;
  logic aux_fault_evt = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic main_on, aux_on, iov, forced, dmode, multi, btn, mflt, aflt, cap66;
  hpa_byte_t cmd_q;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  hpa_link_if lk ();
  hpa_device hpa_device_i (.pclk(pclk), .presetn(presetn), .link(lk.dev), .main_fault_evt(main_fault_evt),
    .aux_fault_evt(aux_fault_evt), .slot_a_main_power_on(main_on), .slot_a_aux_power_on(aux_on),
    .slot_a_iov_3v3(iov), .forced_enable(forced), .direct_mode(dmode), .multi_slot(multi), .button_pressed(btn),
    .slot_a_main_fault_latch(mflt), .slot_a_aux_fault_latch(aflt), .speed66_cap(cap66), .cmd_latched(cmd_q));
  hpa_host hpa_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk.host));
  hpa_link_assertions hpa_link_assertions_i (.pclk(pclk), .presetn(presetn), .supply_ok(lk.supply_ok),
    .direct_strap(lk.direct_strap), .slot_a_serial_clk(lk.slot_a_serial_clk), .slot_a_latch_clk(lk.slot_a_latch_clk),
    .slot_a_aux_switch_n(lk.slot_a_aux_switch_n), .slot_a_clock_enable_n(lk.slot_a_clock_enable_n),
    .dev_so(lk.dev_so), .dev_so_oe(lk.dev_so_oe), .dev_pled_oe(lk.dev_pled_oe), .dev_attn_oe(lk.dev_attn_oe),
    .dev_speed66_oe(lk.dev_speed66_oe));
  always #4 pclk = ~pclk;
  // ==========================================================
  // Hang guard: whole run is about a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  // ==========================================================
  // Shared tasks
  task summarize();
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Pins pass a synchroniser, so give them time before looking
  task settle();
    repeat (10) @(posedge pclk);
  endtask : settle
  task ctrl(input logic [7:0] v);
    apb(1'b1, `HPA_REG_CTRL, {24'h0, v});
    settle();
  endtask : ctrl
  task direct(input logic [3:0] v);
    apb(1'b1, `HPA_REG_DIRECT, {28'h0, v});
    settle();
  endtask : direct
  task status();
    apb(1'b0, `HPA_REG_STATUS, 32'h0);
  endtask : status
  task send(input hpa_byte_t b);
    apb(1'b1, `HPA_REG_CMD, {24'h0, b});
    do status(); while (rd[0] !== 1'b0);
    settle();
  endtask : send
  task fault(input logic aux);
    @(posedge pclk);
    main_fault_evt <= ~aux;
    aux_fault_evt <= aux;
    @(posedge pclk);
    main_fault_evt <= 1'b0;
    aux_fault_evt <= 1'b0;
    settle();
  endtask : fault
  // ==========================================================
  // Scenarios
  task t_direct();
    ctrl(8'h32);
    ctrl(8'h33);
    chk({dmode, multi, forced}, 3'b100);
    direct(4'h1); // Voltage select moves only with power request low
    chk(iov, 1'b1);
    direct(4'h0);
    chk(iov, 1'b0);
    direct(4'h6);
    status();
    chk(rd[17:16], 2'b00);
    direct(4'h8);
    status();
    chk({rd[17:16], main_on}, 3'b111);
    fault(1'b0);
    chk({mflt, main_on}, 2'b10);
    direct(4'h0);
    chk(mflt, 1'b0);
    ctrl(8'h13);
    status();
    chk(rd[18], 1'b0);
    ctrl(8'h32);
  endtask : t_direct
  task t_aux();
    ctrl(8'h22);
    ctrl(8'h23);
    chk(aux_on, 1'b1);
    fault(1'b1);
    chk(aflt, 1'b1);
    ctrl(8'h22);
    status();
    chk({aflt, rd[17]}, 2'b10);
    ctrl(8'h32);
    status();
    chk({aflt, aux_on, rd[17]}, 3'b001);
  endtask : t_aux
  task t_serial();
    ctrl(8'h30);
    ctrl(8'h31);
    status();
    chk({dmode, multi, rd[17:16]}, 4'h3);
    ctrl(8'hb1);
    ctrl(8'h31);
    chk({btn, cap66}, 2'b11);
    ctrl(8'h71);
    chk(cap66, 1'b0);
    ctrl(8'h31);
    send(8'h13);
    status();
    chk({cmd_q, main_on, rd[16]}, {8'h13, 2'b10});
    send(8'h20);
    chk({btn, rd[11:8]}, 5'h09);
  endtask : t_serial
  task t_multi();
    ctrl(8'h3c);
    ctrl(8'h3d);
    chk({multi, forced, main_on}, 3'b111);
    send(8'h5a);
    chk({iov, main_on}, 2'b11);
    send(8'h00);
    chk({rd[15:8], cmd_q}, 16'h5a00);
    ctrl(8'h3f);
    chk(dmode, 1'b0);
  endtask : t_multi
  task t_unmapped();
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_unmapped
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_direct();
    t_aux();
    t_serial();
    t_multi();
    t_unmapped();
    summarize();
  end
endmodule : hot_plug_slot_a_control_pins_tb
